// [pkg/vcide_map.vh]
// constants for the video channel id encoder
`ifndef VCIDE_MAP_VH
`define VCIDE_MAP_VH

// ----------------------------------------------------------------------------
// detection nibble bit positions
// ----------------------------------------------------------------------------
`define VCIDE_DET_LOSS_BIT    3
`define VCIDE_DET_MOTION_BIT  2
`define VCIDE_DET_BLIND_BIT   1
`define VCIDE_DET_NIGHT_BIT   0

// ----------------------------------------------------------------------------
// analog style id line type codes
// ----------------------------------------------------------------------------
`define VCIDE_TYPE_AUTO       3'h0
`define VCIDE_TYPE_REPEAT     3'h1
`define VCIDE_TYPE_DET_LO     3'h2
`define VCIDE_TYPE_DET_HI     3'h3
`define VCIDE_TYPE_USER_A     3'h4
`define VCIDE_TYPE_USER_B     3'h5

// ----------------------------------------------------------------------------
// analog line framing
// ----------------------------------------------------------------------------
`define VCIDE_RUNIN_PATTERN   16'hAAAA
`define VCIDE_RUNIN_BITS      6'h10
`define VCIDE_PAYLOAD_BITS    6'h24
`define VCIDE_FRAME_BITS      6'h34
`define VCIDE_ANALOG_SLOTS    3'h6

// ----------------------------------------------------------------------------
// digital coded id line
// ----------------------------------------------------------------------------
`define VCIDE_CODE_OFFSET     8'h50
`define VCIDE_IDX_AUTO        6'h02
`define VCIDE_IDX_DET         6'h0A
`define VCIDE_IDX_USER        6'h1A
`define VCIDE_IDX_END         6'h2A
`define VCIDE_START_NIBBLE    4'hF
`define VCIDE_END_NIBBLE      4'h0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define VCIDE_LUMA_RESET      8'h00

`endif

// [verilog/vcide_bit_serializer.v]
// serializer that shifts an analog id frame out, msb first, at a set bit width
`timescale 1ns/1ps
`include "vcide_map.vh"

module vcide_bit_serializer (
    input  wire        core_clk_in,    // pixel clock
    input  wire        arst_n_in,      // async reset, active low
    input  wire        start_in,       // one cycle: load frame and begin
    input  wire [51:0] frame_in,       // bits to send, msb first
    input  wire [5:0]  nbits_in,       // number of bits to send
    input  wire [7:0]  width_in,       // pixels per bit, zero acts as one
    output wire        busy_out,       // high while a bit is on the line
    output wire        bit_out         // current bit value
);

    reg [51:0] shreg;
    reg [5:0]  bits_left;
    reg [7:0]  pix_left;

    wire [7:0] width_eff = (width_in == 8'h00) ? 8'h01 : width_in;

    // shift one bit per bit period; a restart mid-frame simply reloads
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shreg     <= 52'h0;
            bits_left <= 6'h00;
            pix_left  <= 8'h00;
        end else if (start_in) begin
            shreg     <= frame_in;
            bits_left <= nbits_in;
            pix_left  <= width_eff;
        end else if (bits_left != 6'h00) begin
            if (pix_left == 8'h01) begin
                shreg     <= {shreg[50:0], 1'b0};
                bits_left <= bits_left - 6'h01;
                pix_left  <= width_eff;
            end else begin
                pix_left  <= pix_left - 8'h01;
            end
        end
    end

    assign busy_out = (bits_left != 6'h00);
    assign bit_out  = shreg[51];

endmodule // vcide_bit_serializer

// [verilog/vcide_code_table.v]
// lookup of the nibble carried by each digital coded id index, registered out
`timescale 1ns/1ps
`include "vcide_map.vh"

module vcide_code_table (
    input  wire        core_clk_in,    // pixel clock
    input  wire        arst_n_in,      // async reset, active low
    input  wire [5:0]  index_in,       // id index 0..63
    input  wire [31:0] auto_bytes_in,  // auto bytes, first at top
    input  wire [63:0] det_bytes_in,   // detection bytes, first at top
    input  wire [63:0] user_bytes_in,  // user bytes, first at top
    output reg  [3:0]  nibble_out      // nibble for index, one cycle later
);

    // offsets inside each field; high nibble of a byte comes first
    wire [5:0] auto_off = index_in - `VCIDE_IDX_AUTO;
    wire [5:0] det_off  = index_in - `VCIDE_IDX_DET;
    wire [5:0] user_off = index_in - `VCIDE_IDX_USER;
    reg  [3:0] next_nibble;

    // index allocation: start, auto, detection, user, end
    always @* begin
        if (index_in < `VCIDE_IDX_AUTO) begin
            next_nibble = `VCIDE_START_NIBBLE;
        end else if (index_in < `VCIDE_IDX_DET) begin
            next_nibble = auto_bytes_in[{~auto_off[2:0], 2'b00} +: 4];
        end else if (index_in < `VCIDE_IDX_USER) begin
            next_nibble = det_bytes_in[{~det_off[3:0], 2'b00} +: 4];
        end else if (index_in < `VCIDE_IDX_END) begin
            next_nibble = user_bytes_in[{~user_off[3:0], 2'b00} +: 4];
        end else begin
            next_nibble = `VCIDE_END_NIBBLE;
        end
    end

    // registered read keeps the long mux off the output path
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nibble_out <= 4'h0;
        end else begin
            nibble_out <= next_nibble;
        end
    end

endmodule // vcide_code_table

// [verilog/vcide_encoder.v]
// channel id encoder: inserts id lines and boundary words into the record luma
`timescale 1ns/1ps
`include "vcide_map.vh"

module vcide_encoder (
    input  wire        core_clk_in,                    // pixel clock, 40 MHz
    input  wire        arst_n_in,                      // async reset, active low
    input  wire [7:0]  luma_in,                        // incoming luma sample
    input  wire        line_start_in,                  // one cycle at line start
    input  wire        vblank_in,                      // vertical blanking level
    input  wire        h_active_in,                    // horizontal active level
    input  wire        field_in,                       // field polarity
    input  wire [15:0] video_loss_flag_in,             // per channel loss
    input  wire [15:0] motion_flag_in,                 // per channel motion
    input  wire [15:0] blind_flag_in,                  // per channel blind
    input  wire [15:0] night_flag_in,                  // per channel night
    input  wire [3:0]  region_enable_in,               // per region active
    input  wire [3:0]  new_event_in,                   // per region new event
    input  wire        sequence_unit_flag_in,          // 0 frame, 1 field
    input  wire [3:0]  switch_position_flag_in,        // per region switch
    input  wire [7:0]  cascade_stage_in,               // per region stage
    input  wire [7:0]  input_path_index_in,            // per region path
    input  wire [31:0] user_bytes_group_a_in,          // user bytes 0..3
    input  wire [31:0] user_bytes_group_b_in,          // user bytes 4..7
    input  wire        auto_id_enable_in,              // auto line enable
    input  wire        auto_id_repeat_enable_in,       // repeat line enable
    input  wire        detect_id_enable_in,            // detection enable
    input  wire        user_id_enable_in,              // user enable
    input  wire        digital_id_enable_in,           // digital line enable
    input  wire        run_in_enable_in,               // run-in clock enable
    input  wire        nonrealtime_detect_format_in,   // eight channel format
    input  wire [7:0]  id_vertical_start_in,           // first id line in vbi
    input  wire [7:0]  id_horizontal_start_in,         // start pixel / 2
    input  wire [7:0]  id_bit_width_in,                // pixels per bit
    input  wire [7:0]  id_one_level_in,                // luma for a one
    input  wire [7:0]  id_zero_level_in,               // luma for a zero
    input  wire        boundary_id_enable_in,          // boundary word enable
    input  wire        ch_boundary_in,                 // one cycle at boundary
    input  wire [1:0]  boundary_region_in,             // region of boundary
    output reg  [7:0]  luma_out,                       // outgoing luma
    output reg         id_insert_out                   // luma replaced
);

    // ------------------------------------------------------------------------
    // line modes
    // ------------------------------------------------------------------------
    localparam [1:0] MODE_PASS    = 2'h0;
    localparam [1:0] MODE_DIGITAL = 2'h1;
    localparam [1:0] MODE_ANALOG  = 2'h2;

    reg  [1:0] line_mode;
    reg  [2:0] slot;
    reg  [8:0] vbi_line;
    reg        in_vbi;
    reg  [8:0] active_line_index;
    reg  [9:0] pix_cnt;
    reg  [6:0] dig_cnt;
    reg        bnd_phase;
    reg  [7:0] bnd_low;
    reg        started;
    // frame start is declared early because the counters below watch it
    wire       ana_start;

    // ------------------------------------------------------------------------
    // id content
    // ------------------------------------------------------------------------
    wire [63:0] det_bytes;
    wire [31:0] auto_bytes;

    genvar gi;
    generate
        // each channel's nibble lands in stage order, two bytes per chip
        // byte k holds channel 2k in its high nibble, 2k+1 in its low
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_det
            assign det_bytes[63-4*gi -: 4] = {video_loss_flag_in[gi],
                                              motion_flag_in[gi],
                                              blind_flag_in[gi],
                                              night_flag_in[gi]};
        end
        // region 0 is left top and goes first; the auto bytes then run
        // right top, left bottom and right bottom
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_auto
            assign auto_bytes[31-8*gi -: 8] = {region_enable_in[gi],
                                               new_event_in[gi],
                                               sequence_unit_flag_in,
                                               switch_position_flag_in[gi],
                                               cascade_stage_in[2*gi +: 2],
                                               input_path_index_in[2*gi +: 2]};
        end
    endgenerate

    // ------------------------------------------------------------------------
    // vbi line counting and line mode decode
    // ------------------------------------------------------------------------
    wire [8:0] next_vbi_line = (vblank_in && in_vbi) ? (vbi_line + 9'h001) : 9'h000;
    wire [8:0] rel_line      = next_vbi_line - {1'b0, id_vertical_start_in};
    wire [8:0] ana_line      = rel_line - {8'h00, digital_id_enable_in};
    reg  [1:0] next_mode;
    reg        slot_on;

    // vbi line 0 is the first blanking line; the six analog slots keep
    // fixed places after the digital line, so a disabled slot leaves its
    // line untouched instead of pulling the later slots up
    // the analog lines sit right after the digital line when it is enabled
    always @* begin
        next_mode = MODE_PASS;
        case (ana_line[2:0])
            3'h0:    slot_on = auto_id_enable_in;
            3'h1:    slot_on = auto_id_enable_in && auto_id_repeat_enable_in;
            3'h2:    slot_on = detect_id_enable_in;
            3'h3:    slot_on = detect_id_enable_in && !nonrealtime_detect_format_in;
            3'h4:    slot_on = user_id_enable_in;
            3'h5:    slot_on = user_id_enable_in;
            default: slot_on = 1'b0;
        endcase
        if (vblank_in) begin
            if (digital_id_enable_in && rel_line == 9'h000) begin
                next_mode = MODE_DIGITAL;
            end else if (ana_line < {6'h00, `VCIDE_ANALOG_SLOTS} && slot_on) begin
                next_mode = MODE_ANALOG;
            end
        end
    end

    // line state is decided once per line, at its start
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            line_mode         <= MODE_PASS;
            slot              <= 3'h0;
            vbi_line          <= 9'h000;
            in_vbi            <= 1'b0;
            active_line_index <= 9'h000;
        end else if (line_start_in) begin
            line_mode <= next_mode;
            slot      <= ana_line[2:0];
            vbi_line  <= next_vbi_line;
            in_vbi    <= vblank_in;
            if (vblank_in) begin
                active_line_index <= 9'h000;
            end else if (in_vbi) begin
                active_line_index <= 9'h000;
            end else begin
                active_line_index <= active_line_index + 9'h001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // pixel and digital sample counters
    // ------------------------------------------------------------------------
    // the code sequence wraps every 128 samples, so more than five copies fit
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pix_cnt <= 10'h000;
            dig_cnt <= 7'h00;
            started <= 1'b0;
        end else if (line_start_in) begin
            pix_cnt <= 10'h000;
            dig_cnt <= 7'h00;
            started <= 1'b0;
        end else begin
            // saturate so an overlong line never wraps onto the start pixel
            if (pix_cnt != 10'h3FF) begin
                pix_cnt <= pix_cnt + 10'h001;
            end
            if (ana_start) begin
                started <= 1'b1;
            end
            if (line_mode == MODE_DIGITAL && h_active_in) begin
                dig_cnt <= dig_cnt + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // analog line frame
    // ------------------------------------------------------------------------
    reg  [31:0] ana_data;
    reg  [2:0]  ana_type;

    // slot picks the four payload bytes and their type code
    always @* begin
        case (slot)
            3'h0: begin
                ana_data = auto_bytes;
                ana_type = `VCIDE_TYPE_AUTO;
            end
            3'h1: begin
                ana_data = auto_bytes;
                ana_type = `VCIDE_TYPE_REPEAT;
            end
            3'h2: begin
                ana_data = det_bytes[63:32];
                ana_type = `VCIDE_TYPE_DET_LO;
            end
            3'h3: begin
                ana_data = det_bytes[31:0];
                ana_type = `VCIDE_TYPE_DET_HI;
            end
            3'h4: begin
                ana_data = user_bytes_group_a_in;
                ana_type = `VCIDE_TYPE_USER_A;
            end
            default: begin
                ana_data = user_bytes_group_b_in;
                ana_type = `VCIDE_TYPE_USER_B;
            end
        endcase
    end

    // parity covers data and type so the 36-bit payload has even ones
    wire        ana_parity = ^{ana_data, ana_type};
    wire [35:0] payload    = {ana_data, ana_type, ana_parity};
    wire [51:0] frame      = run_in_enable_in ? {`VCIDE_RUNIN_PATTERN, payload}
                                              : {payload, 16'h0000};
    wire [5:0]  nbits      = run_in_enable_in ? `VCIDE_FRAME_BITS : `VCIDE_PAYLOAD_BITS;
    assign      ana_start  = (line_mode == MODE_ANALOG) && !started
                             && (pix_cnt == {1'b0, id_horizontal_start_in, 1'b0});
    wire        ana_busy;
    wire        ana_bit;

    // limitation: the frame is not cut at the next line start, so 52 bits
    // times the bit width must fit between the start pixel and line end
    vcide_bit_serializer u_serializer (
        .core_clk_in (core_clk_in),
        .arst_n_in   (arst_n_in),
        .start_in    (ana_start),
        .frame_in    (frame),
        .nbits_in    (nbits),
        .width_in    (id_bit_width_in),
        .busy_out    (ana_busy),
        .bit_out     (ana_bit)
    );

    // ------------------------------------------------------------------------
    // digital coded line
    // ------------------------------------------------------------------------
    wire [3:0] code_nibble;

    // the table answers one cycle late, just when the odd sample needs it
    vcide_code_table u_code_table (
        .core_clk_in   (core_clk_in),
        .arst_n_in     (arst_n_in),
        .index_in      (dig_cnt[6:1]),
        .auto_bytes_in (auto_bytes),
        .det_bytes_in  (det_bytes),
        .user_bytes_in ({user_bytes_group_a_in, user_bytes_group_b_in}),
        .nibble_out    (code_nibble)
    );

    // ------------------------------------------------------------------------
    // boundary word
    // ------------------------------------------------------------------------
    wire [15:0] bnd_word = {active_line_index,
                            field_in,
                            region_enable_in[boundary_region_in],
                            switch_position_flag_in[boundary_region_in],
                            cascade_stage_in[{boundary_region_in, 1'b0} +: 2],
                            input_path_index_in[{boundary_region_in, 1'b0} +: 2]};
    wire        bnd_hit  = boundary_id_enable_in && ch_boundary_in
                           && h_active_in && !vblank_in;

    // the low byte is held so the word survives a boundary at a line edge
    // trade-off: a hit right after another takes the bus and the earlier
    // word loses its low byte; channels are never that narrow
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bnd_phase <= 1'b0;
            bnd_low   <= 8'h00;
        end else begin
            bnd_phase <= bnd_hit;
            if (bnd_hit) begin
                bnd_low <= bnd_word[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // output selection
    // ------------------------------------------------------------------------
    reg [7:0] next_luma;
    reg       next_insert;

    // analog bits outrank everything; boundary words only occur in active lines
    always @* begin
        next_luma   = luma_in;
        next_insert = 1'b0;
        if (ana_busy) begin
            next_luma   = ana_bit ? id_one_level_in : id_zero_level_in;
            next_insert = 1'b1;
        end else if (line_mode == MODE_DIGITAL && h_active_in) begin
            next_insert = 1'b1;
            if (!dig_cnt[0]) begin
                next_luma = {2'b00, dig_cnt[6:1]};
            end else begin
                next_luma = `VCIDE_CODE_OFFSET | {4'h0, code_nibble};
            end
        end else if (bnd_hit) begin
            next_luma   = bnd_word[15:8];
            next_insert = 1'b1;
        end else if (bnd_phase) begin
            next_luma   = bnd_low;
            next_insert = 1'b1;
        end
    end

    // one register stage on the video path
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            luma_out      <= `VCIDE_LUMA_RESET;
            id_insert_out <= 1'b0;
        end else begin
            luma_out      <= next_luma;
            id_insert_out <= next_insert;
        end
    end

endmodule // vcide_encoder

// [sim/vcide_recorder_model.sv]
// downstream recorder model: counts replaced luma samples
`timescale 1ns/1ps
module vcide_recorder_model (
    input  wire        core_clk_in,   // pixel clock
    input  wire        arst_n_in,     // async reset, active low
    input  wire        id_insert_in,  // replaced sample flag
    output reg  [15:0] ins_count_out  // replaced samples seen
);
    // a recorder only listens; it never stalls the stream
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) ins_count_out <= 16'h0000;
        else if (id_insert_in) ins_count_out <= ins_count_out + 16'h0001;
    end
endmodule // vcide_recorder_model

// [sim/vcide_encoder_chk.sv]
// port checker for the channel id encoder
`timescale 1ns/1ps
module vcide_encoder_chk (
    input wire       core_clk_in, arst_n_in, vblank_in, h_active_in, field_in, ch_boundary_in, // timing
    input wire       auto_id_enable_in, detect_id_enable_in, user_id_enable_in, digital_id_enable_in, // enables
    input wire       boundary_id_enable_in, id_insert_out, // boundary enable, insert flag
    input wire [7:0] luma_in, luma_out, id_one_level_in, id_zero_level_in, // luma and levels
    input wire [7:0] cascade_stage_in, input_path_index_in, // per region pairs
    input wire [3:0] region_enable_in, switch_position_flag_in, // per region bits
    input wire [1:0] boundary_region_in // region of the boundary
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);
    wire dig = vblank_in & digital_id_enable_in & ~(auto_id_enable_in | detect_id_enable_in | user_id_enable_in);
    wire bnd = ch_boundary_in & boundary_id_enable_in & h_active_in & ~vblank_in;
    reg  [6:0] exp_lo;
    // low byte leaves two cycles after the pulse, so hold its fields here
    always @(posedge core_clk_in) if (ch_boundary_in) exp_lo <= {field_in, region_enable_in[boundary_region_in],
        switch_position_flag_in[boundary_region_in], cascade_stage_in[2*boundary_region_in+:2],
        input_path_index_in[2*boundary_region_in+:2]};
    a_pass_through: assert property ($past(arst_n_in) && !id_insert_out |-> luma_out == $past(luma_in))
        else $error("luma not passed");
    a_bound_words: assert property (bnd |=> id_insert_out ##1 (id_insert_out && luma_out[6:0] == exp_lo))
        else $error("boundary word wrong");
    a_bound_off: assert property (ch_boundary_in && !boundary_id_enable_in && !vblank_in |=> !id_insert_out)
        else $error("boundary word while disabled");
    a_start_code: assert property (dig && id_insert_out && luma_out == 8'h00 |=> !id_insert_out || luma_out == 8'h5F)
        else $error("start code wrong");
    a_end_code: assert property (dig && id_insert_out && luma_out >= 8'h2A && luma_out < 8'h40
        |=> !id_insert_out || luma_out == 8'h50) else $error("end code wrong");
    a_index_step: assert property (dig && id_insert_out && luma_out < 8'h3F |=> 1'b1 ##1
        (!id_insert_out || luma_out == $past(luma_out, 2) + 8'h01)) else $error("index step wrong");
    a_offset_nib: assert property (dig && id_insert_out && luma_out < 8'h40 |=> !id_insert_out || luma_out[7:4] == 4'h5)
        else $error("nibble offset wrong");
    a_ana_level: assert property (vblank_in && !digital_id_enable_in && id_insert_out
        |-> luma_out == id_one_level_in || luma_out == id_zero_level_in) else $error("analog level wrong");
    c_bound: cover property (bnd);
    c_digital: cover property (dig && id_insert_out);
    c_analog: cover property (vblank_in && !digital_id_enable_in && id_insert_out);
endmodule // vcide_encoder_chk
bind vcide_encoder vcide_encoder_chk vcide_encoder_chk_i (.*);

// [sim/vcide_encoder_bench.sv]
// self-checking bench for the channel id encoder
`timescale 1ns/1ps
module vcide_encoder_bench;
    reg core_clk_in = 0, arst_n_in = 0, line_start_in = 0, vblank_in = 0, h_active_in = 0, field_in = 1;
    reg sequence_unit_flag_in = 1, auto_id_enable_in = 0, auto_id_repeat_enable_in = 1, detect_id_enable_in = 0;
    reg user_id_enable_in = 0, digital_id_enable_in = 1, run_in_enable_in = 1, nonrealtime_detect_format_in = 0;
    reg boundary_id_enable_in = 1, ch_boundary_in = 0;
    reg [1:0]  boundary_region_in = 2'h0;
    reg [3:0]  region_enable_in = 4'h5, new_event_in = 4'h0, switch_position_flag_in = 4'h3;
    reg [7:0]  luma_in = 8'h00, cascade_stage_in = 8'hE4, input_path_index_in = 8'h1B, id_vertical_start_in = 8'h01;
    reg [7:0]  id_horizontal_start_in = 8'h14, id_bit_width_in = 8'h03, id_one_level_in = 8'hC8, id_zero_level_in = 8'h10;
    reg [15:0] video_loss_flag_in = 16'h0001, motion_flag_in = 16'h0010, blind_flag_in = 16'h0100, night_flag_in = 16'h1000;
    reg [31:0] user_bytes_group_a_in = 32'h12345678, user_bytes_group_b_in = 32'h9ABCDEF0;
    wire [7:0]  luma_out;
    wire        id_insert_out;
    wire [15:0] ins_count;
    integer     miscompares = 0, num_checks = 0, i, r;
    reg [9:0]   rows [0:3];
    reg [167:0] dvec = {8'hFF, 32'hB336A92C, 64'h8000400020001000, 64'h123456789ABCDEF0}; // id content 0..41
    vcide_encoder vcide_encoder_i (.*);
    vcide_recorder_model vcide_recorder_model_i (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .id_insert_in(id_insert_out), .ins_count_out(ins_count));
    always #12.5 core_clk_in = ~core_clk_in;
    // moving luma shows whether untouched samples really pass through
    always @(negedge core_clk_in) luma_in <= luma_in + 8'h01;
    task check(input [7:0] seen, input [7:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks=%0d miscompares=%0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // line start pulse, short blanking, then active samples begin
    task vline(input vb);
        begin
            @(negedge core_clk_in) vblank_in = vb;
            line_start_in = 1;
            @(negedge core_clk_in) line_start_in = 0;
            repeat (8) @(negedge core_clk_in);
            h_active_in = 1;
        end
    endtask
    // 720 active samples leave room for more than five digital sequences
    task vend;
        begin
            repeat (720) @(negedge core_clk_in);
            h_active_in = 0;
            repeat (8) @(negedge core_clk_in);
        end
    endtask
    // bounded wait for the first replaced sample of a line
    task wait_ins;
        begin
            i = 0;
            while (id_insert_out !== 1'b1 && i < 400) begin
                @(negedge core_clk_in);
                i = i + 1;
            end
            check({7'h00, id_insert_out}, 8'h01);
        end
    endtask
    initial begin
        rows[0] = 10'h073; rows[1] = 10'h156; rows[2] = 10'h269; rows[3] = 10'h34C;
        repeat (20) @(negedge core_clk_in);
        check(luma_out, 8'h00);
        check({7'h00, id_insert_out}, 8'h00);
        arst_n_in = 1;
        vline(0); vend; vline(1); vend; vline(1);
        wait_ins;
        for (r = 0; r < 84; r = r + 1) begin
            check(luma_out, r[0] ? {4'h5, dvec[167-4*(r/2) -: 4]} : r / 2);
            @(negedge core_clk_in);
        end
        vend;
        digital_id_enable_in = 0;
        auto_id_enable_in = 1;
        vline(1);
        wait_ins;
        check(luma_out, 8'hC8);
        repeat (3) @(negedge core_clk_in);
        check(luma_out, 8'h10);
        repeat (45) @(negedge core_clk_in);
        check(luma_out, 8'hC8);
        repeat (99) @(negedge core_clk_in);
        check(luma_out, 8'h10);
        repeat (3) @(negedge core_clk_in);
        check(luma_out, 8'hC8);
        repeat (3) @(negedge core_clk_in);
        check(luma_out, 8'hC8);
        repeat (3) @(negedge core_clk_in);
        check({7'h00, id_insert_out}, 8'h00);
        vend; vline(0);
        repeat (20) @(negedge core_clk_in);
        for (r = 0; r < 4; r = r + 1) begin
            boundary_region_in = rows[r][9:8];
            ch_boundary_in = 1;
            @(negedge core_clk_in) ch_boundary_in = 0;
            check(luma_out, 8'h00);
            @(negedge core_clk_in) check(luma_out, rows[r][7:0]);
            repeat (4) @(negedge core_clk_in);
        end
        boundary_id_enable_in = 0;
        ch_boundary_in = 1;
        @(negedge core_clk_in) ch_boundary_in = 0;
        check({7'h00, id_insert_out}, 8'h00);
        vend;
        check({7'h00, ins_count != 16'h0000}, 8'h01);
        final_report;
    end
    // watchdog sized well past the five lines of traffic
    initial begin
        repeat (20000) @(posedge core_clk_in);
        miscompares = miscompares + 1;
        final_report;
    end
endmodule // vcide_encoder_bench
